//--- bench/clt_host.sv
// Bus master model standing in for the processor or DMA engine
`timescale 1ns/1ps
`default_nettype none
module clt_host
  import clt_pkg::*;
(
  input  wire logic          CLK,
  output var clt_bus_s       BUS_REQ,
  input  wire logic [DW-1:0] BUS_RDATA
);
  //==========================================================================
  // Bus cycles
  initial BUS_REQ = '0; // Idle from time zero
  // Write: raised after an edge, held to the taking edge
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge CLK);
    BUS_REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge CLK);
    BUS_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d}; // Released lines lose old value
  endtask : wr
  // Read: data lands at the taking edge, picked up once it settles
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge CLK);
    BUS_REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
    @(posedge CLK);
    BUS_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
    #1;
    d = BUS_RDATA;
  endtask : rd
endmodule : clt_host
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench of the configurable logic tile
`timescale 1ns/1ps
`default_nettype none
module testbench
  import clt_pkg::*;
;
  //==========================================================================
  // Signals
  logic                          clk, rst, chain_co, chain_so, stall, chain_ci, chain_si;
  clt_bus_s                      bus_req;
  logic [DW-1:0]                 rdata, par_in, par_out, v, a, b, r, cw;
  logic [N_ARR-1:0][ARR_NIN-1:0]  arr_in;
  logic [N_ARR-1:0][ARR_NOUT-1:0] arr_out;
  logic [CS_AW-1:0]              cfg_sel;
  clt_cond_s                     cond;
  logic [31:0]                   r32;
  logic                          e;
  int                            n_errors = 0, cmp_count = 0, seed = 32'h70cf8f3a;
  // Chain inputs random: words here leave them disabled, so they must not matter
  clt_tile i_dut (.CLK(clk), .RST(rst), .BUS_REQ(bus_req), .BUS_RDATA(rdata),
    .ARR_IN(arr_in), .ARR_OUT(arr_out), .CFG_SEL(cfg_sel), .PAR_IN(par_in),
    .PAR_OUT(par_out), .COND(cond), .CHAIN_CI(chain_ci), .CHAIN_SI(chain_si),
    .CHAIN_CO(chain_co), .CHAIN_SO(chain_so), .STALL(stall));
  clt_host i_host (.CLK(clk), .BUS_REQ(bus_req), .BUS_RDATA(rdata));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //==========================================================================
  // Checking helpers
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic rchk(input logic [AW-1:0] ad, input logic [7:0] ex, input string nm);
    i_host.rd(ad, v);
    chk(nm, ex, v);
  endtask : rchk
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Reference ALU; pass left out as its operand is not pinned down
  function automatic logic [7:0] alu(input logic [2:0] f, input logic [7:0] x, input logic [7:0] y);
    case (f)
      3'h0: return x + 8'h01;
      3'h1: return x - 8'h01;
      3'h2: return x + y;
      3'h3: return x - y;
      3'h4: return x & y;
      3'h5: return x | y;
      default: return x ^ y;
    endcase
  endfunction : alu
  // Watchdog, far beyond the roughly three hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  //==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1; cfg_sel = '0; par_in = '0; arr_in = '0; chain_ci = 1'b0; chain_si = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("cond", 8'h78, {1'b0, cond});
    for (int i = 0; i < 4; i++) rchk(8'(i), 8'h00, "reg_reset");
    rchk(ADR_STAT, 8'h05, "stat_reset");
    repeat (8) begin
      r32 = $random(seed);
      i_host.wr({6'h00, r32[9:8]}, r32[7:0]);
      rchk({6'h00, r32[9:8]}, r32[7:0], "reg_rw");
    end
    i_host.wr(ADR_STAT, 8'hFF);
    rchk(ADR_STAT, 8'h05, "stat_ro");
    i_host.wr(8'h08, 8'h5A);
    rchk(8'h08, 8'h00, "unmapped");
    // Every function but pass once, second operand alternating register and routing
    for (int i = 0; i < 7; i++) begin
      a = $random(seed); b = $random(seed); r32 = $random(seed);
      cw = {2'h2, (i[0] ? SB_PI : SB_OPR1), 1'b0, i[2:0]};
      i_host.wr(ADR_ACC0, a); i_host.wr(ADR_OPR1, b);
      i_host.wr(ADR_CS + 8'h02, cw); i_host.wr(ADR_CS + 8'h03, 8'h00);
      @(posedge clk);
      par_in <= i[0] ? b : ~b;
      {chain_ci, chain_si} <= r32[1:0];
      cfg_sel <= 3'h1;
      #1 if (i == 2) chk("carry", 8'((9'(a) + 9'(b)) >> 8), {7'h00, chain_co});
      @(posedge clk);
      cfg_sel <= '0;
      r = alu(i[2:0], a, b);
      #1 chk("par_out", r, par_out);
      rchk(ADR_ACC1, r, "acc1");
      rchk(ADR_OPR1, b, "opr1");
      chk("zero1", {7'h00, r == 8'h00}, {7'h00, cond.zero[1]});
    end
    // Fill both queues past full, then drain both, queue zero past empty
    for (int i = 0; i < 5; i++) begin
      i_host.wr(ADR_Q0, 8'h10 + 8'(i)); i_host.wr(ADR_Q1, 8'h20 + 8'(i));
    end
    rchk(ADR_STAT, 8'h0A, "stat_full");
    for (int i = 0; i < 4; i++) begin
      rchk(ADR_Q0, 8'h10 + 8'(i), "q0");
      rchk(ADR_Q1, 8'h20 + 8'(i), "q1");
    end
    rchk(ADR_Q0, 8'h00, "q0_empty");
    // Word 2 loads operand zero from queue zero and captures acc zero
    a = $random(seed); b = $random(seed);
    i_host.wr(ADR_CS + 8'h04, 8'h00); i_host.wr(ADR_CS + 8'h05, 8'h14); i_host.wr(ADR_ACC0, a);
    @(posedge clk);
    cfg_sel <= 3'h2;
    @(posedge clk);
    #1 chk("stall", 8'h01, {7'h00, stall});
    i_host.wr(ADR_Q0, b);
    repeat (2) @(posedge clk);
    cfg_sel <= '0;
    rchk(ADR_OPR0, b, "load");
    rchk(ADR_Q1, a, "capture");
    rchk(ADR_STAT, 8'h05, "stat_one");
    // Array 0: term 0 is in3 and not in5, OR to out0 plain, out1 registered
    i_host.wr(ADR_CFG, 8'h08); i_host.wr(ADR_CFG + 8'd2, 8'h02);
    i_host.wr(ADR_CFG + 8'd24, 8'h01); i_host.wr(ADR_CFG + 8'd25, 8'h01);
    i_host.wr(ADR_CFG + 8'd28, 8'h02);
    repeat (16) begin
      r32 = $random(seed);
      @(posedge clk);
      arr_in <= r32[23:0];
      @(posedge clk);
      e = r32[3] & ~r32[5];
      #1 chk("arr_comb", {7'h00, e}, {7'h00, arr_out[0][0]});
      chk("arr_reg", {7'h00, e}, {7'h00, arr_out[0][1]});
      chk("arr_one", 8'h00, {4'h0, arr_out[1]});
    end
    end_sim();
  end
endmodule : testbench
`default_nettype wire

//--- src/clt_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module clt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire logic [WIDTH-1:0]      in_data,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output logic [WIDTH-1:0]           out_data,
  output logic [$clog2(DEPTH):0]     level
);
  //==========================================================================
  // Storage and pointers; DEPTH must be a power of two so pointers wrap
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // Entries
  logic [PW-1:0]    wr_ptr;        // Next slot to fill
  logic [PW-1:0]    rd_ptr;        // Oldest entry
  wire  logic       push;
  wire  logic       pop;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  // Full and empty come from the level, never from pointer equality
  assign in_ready  = (level != (PW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  //==========================================================================
  // Entry write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // Pointers and level
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      wr_ptr <= wr_ptr + PW'(push);
      rd_ptr <= rd_ptr + PW'(pop);
      level  <= level + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : clt_fifo
`default_nettype wire

//--- src/clt_pkg.sv
// Shared map, field layouts and types of the configurable logic tile
//==========================================================================
// Contract
// RQ1 - Each array takes twelve routing inputs, eight terms
// RQ2 - Term ANDs 1..12 inputs, true or complement
// RQ3 - Output ORs up to eight terms, fixed width
// RQ4 - Each output registered or combinational, selectable
// RQ5 - Two product-term arrays plus one datapath
// RQ6 - 8-bit single-cycle ALU with condition logic
// RQ7 - Eight 16-bit control words select operation
// RQ8 - Two compares, zero, ones flags, overflow
// RQ9 - Six working registers reachable by bus master
// RQ10 - Accumulators are ALU source, sink, compare source
// RQ11 - Operand registers are sources only, never sinks
// RQ12 - Each byte queue holds four bytes
// RQ13 - Queues load registers or capture results
// RQ14 - Queues are main bus-to-datapath data path
// RQ15 - All datapath registers bus readable and writable
// RQ16 - Carry and shift chain to neighbour datapaths
// RQ17 - Parallel input and output to routing
// RQ18 - ALU result lands in accumulator same edge
package clt_pkg;
  //==========================================================================
  // Widths and sizes
  localparam int DW        = 8;   // Datapath and bus data width
  localparam int AW        = 8;   // Bus address width
  localparam int N_ARR     = 2;   // Product-term arrays per tile
  localparam int ARR_NIN   = 12;  // Routing inputs per array
  localparam int PT_N      = 8;   // Product terms per array
  localparam int ARR_NOUT  = 4;   // Sum outputs per array
  localparam int CS_DEPTH  = 8;   // Control store words
  localparam int CS_W      = 16;  // Control store word width
  localparam int CS_AW     = 3;   // Control store address width
  localparam int Q_DEPTH   = 4;   // Byte queue depth
  localparam int Q_LW      = 3;   // Byte queue level width
  localparam int CFG_BYTES = 64;  // Array configuration bytes
  localparam int ARR_CFG   = 32;  // Configuration bytes per array
  localparam int PT_BYTES  = 3;   // Bytes per product term
  localparam int ARR_OR_OFS  = 24; // First OR-mask byte in an array block
  localparam int ARR_REG_OFS = 28; // Registered-mode byte in an array block
  //==========================================================================
  // Register map
  localparam logic [AW-1:0] ADR_ACC0 = 8'h00;
  localparam logic [AW-1:0] ADR_ACC1 = 8'h01;
  localparam logic [AW-1:0] ADR_OPR0 = 8'h02;
  localparam logic [AW-1:0] ADR_OPR1 = 8'h03;
  localparam logic [AW-1:0] ADR_Q0   = 8'h04;
  localparam logic [AW-1:0] ADR_Q1   = 8'h05;
  localparam logic [AW-1:0] ADR_STAT = 8'h06;
  localparam logic [AW-1:0] ADR_CS   = 8'h10; // Word i low byte at 2i, high at 2i+1
  localparam logic [AW-1:0] CS_MASK  = 8'hF0;
  localparam logic [AW-1:0] ADR_CFG  = 8'h40; // 64 array configuration bytes
  localparam logic [AW-1:0] CFG_MASK = 8'hC0;
  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DW-1:0] BYTE_ONES = 8'hFF;
  //==========================================================================
  // Control word encodings
  typedef enum logic [2:0] {
    FN_INC = 3'h0, FN_DEC = 3'h1, FN_ADD = 3'h2, FN_SUB = 3'h3,
    FN_AND = 3'h4, FN_OR  = 3'h5, FN_XOR = 3'h6, FN_PASS = 3'h7
  } clt_func_e;
  localparam logic [1:0] DST_NONE = 2'h0, DST_ACC0 = 2'h1, DST_ACC1 = 2'h2;
  localparam logic [1:0] SB_OPR0 = 2'h0, SB_OPR1 = 2'h1, SB_PI = 2'h2, SB_ACC1 = 2'h3;
  localparam logic [1:0] SH_NONE = 2'h0, SH_LEFT = 2'h1, SH_RIGHT = 2'h2, SH_SWAP = 2'h3;
  localparam logic [1:0] FL_NONE = 2'h0, FL_OPR0 = 2'h1, FL_OPR1 = 2'h2, FL_ACC0 = 2'h3;
  localparam logic [1:0] FC_NONE = 2'h0, FC_ACC0 = 2'h1, FC_ACC1 = 2'h2, FC_ALU = 2'h3;
  //==========================================================================
  // Carriers
  typedef struct packed {
    logic       chain_sh;  // Shift-in from neighbour
    logic       chain_ci;  // Carry-in from neighbour
    logic [1:0] q1_cap;    // Queue one capture source
    logic [1:0] q0_load;   // Queue zero load target
    logic [1:0] shift;     // Post-ALU shift
    logic [1:0] dest;      // Result accumulator
    logic [1:0] src_b;     // Second operand
    logic       src_a;     // First operand: acc zero or one
    clt_func_e  func;      // ALU function
  } clt_cw_s;
  typedef struct packed {
    logic            wr;
    logic            rd;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   wdata;
  } clt_bus_s;
  typedef struct packed {
    logic [1:0] cmp;   // Acc equals operand register
    logic [1:0] zero;  // Acc is zero
    logic [1:0] ones;  // Acc is all ones
    logic       ovf;   // Signed overflow of the previous cycle, zero when that cycle stalled
  } clt_cond_s;
endpackage : clt_pkg

//--- src/clt_tile.sv
// Configurable logic tile: two product-term arrays and an 8-bit datapath
`timescale 1ns/1ps
`default_nettype none
module clt_tile
  import clt_pkg::*;
(
  input  wire logic                         CLK,
  input  wire logic                         RST,
  input  wire clt_bus_s                     BUS_REQ,
  output logic [DW-1:0]                     BUS_RDATA,
  input  wire logic [N_ARR-1:0][ARR_NIN-1:0] ARR_IN,
  output logic [N_ARR-1:0][ARR_NOUT-1:0]     ARR_OUT,
  input  wire logic [CS_AW-1:0]             CFG_SEL,
  input  wire logic [DW-1:0]                PAR_IN,
  output logic [DW-1:0]                     PAR_OUT,
  output clt_cond_s                         COND,
  input  wire logic                         CHAIN_CI,
  input  wire logic                         CHAIN_SI,
  output logic                              CHAIN_CO,
  output logic                              CHAIN_SO,
  output logic                              STALL
);
  //==========================================================================
  // State
  logic [DW-1:0]   acc0;                  // Accumulator zero
  logic [DW-1:0]   acc1;                  // Accumulator one
  logic [DW-1:0]   opr0;                  // Operand register zero
  logic [DW-1:0]   opr1;                  // Operand register one
  logic [CS_W-1:0] cstore [CS_DEPTH];     // Control store
  logic [DW-1:0]   cfg [CFG_BYTES];       // Array configuration bytes
  clt_cond_s       cond_q;                // Registered conditions
  logic [DW-1:0]   par_q;                 // Registered parallel output
  //==========================================================================
  // Bus decode
  wire logic wr_acc0, wr_acc1, wr_opr0, wr_opr1, wr_q0, wr_q1, wr_cs, wr_cfg;
  wire logic rd_q0, rd_q1;
  assign wr_acc0 = BUS_REQ.wr & (BUS_REQ.addr == ADR_ACC0);
  assign wr_acc1 = BUS_REQ.wr & (BUS_REQ.addr == ADR_ACC1);
  assign wr_opr0 = BUS_REQ.wr & (BUS_REQ.addr == ADR_OPR0);
  assign wr_opr1 = BUS_REQ.wr & (BUS_REQ.addr == ADR_OPR1);
  assign wr_q0   = BUS_REQ.wr & (BUS_REQ.addr == ADR_Q0);
  assign wr_q1   = BUS_REQ.wr & (BUS_REQ.addr == ADR_Q1);
  assign wr_cs   = BUS_REQ.wr & ((BUS_REQ.addr & CS_MASK) == ADR_CS);
  assign wr_cfg  = BUS_REQ.wr & ((BUS_REQ.addr & CFG_MASK) == ADR_CFG);
  assign rd_q0   = BUS_REQ.rd & (BUS_REQ.addr == ADR_Q0);
  assign rd_q1   = BUS_REQ.rd & (BUS_REQ.addr == ADR_Q1);
  //==========================================================================
  // Configuration storage, written byte by byte from the bus
  always_ff @(posedge CLK) begin
    for (int i = 0; i < CS_DEPTH; i++) begin
      if (RST) begin
        cstore[i] <= '0;
      end else if (wr_cs && (BUS_REQ.addr[CS_AW:1] == CS_AW'(i))) begin
        if (BUS_REQ.addr[0]) begin
          cstore[i][CS_W-1:DW] <= BUS_REQ.wdata;
        end else begin
          cstore[i][DW-1:0] <= BUS_REQ.wdata;
        end
      end
    end
  end
  // Array configuration bytes
  always_ff @(posedge CLK) begin
    for (int i = 0; i < CFG_BYTES; i++) begin
      if (RST) begin
        cfg[i] <= '0;
      end else if (wr_cfg && (BUS_REQ.addr[5:0] == 6'(i))) begin
        cfg[i] <= BUS_REQ.wdata;
      end
    end
  end
  //==========================================================================
  // Product-term arrays, one generate copy per array
  for (genvar a = 0; a < N_ARR; a++) begin : g_arr  // [RQ5]
    localparam int B = a * ARR_CFG;
    logic [PT_N-1:0]     term;   // Product terms
    logic [ARR_NOUT-1:0] sop;    // Combinational sums
    logic [ARR_NOUT-1:0] sop_q;  // Registered sums
    wire  logic [ARR_NOUT-1:0] reg_mode;
    for (genvar t = 0; t < PT_N; t++) begin : g_pt
      wire logic [ARR_NIN-1:0] en_t;  // True-polarity enables
      wire logic [ARR_NIN-1:0] en_c;  // Complement enables
      assign en_t = {cfg[B+PT_BYTES*t+1][3:0], cfg[B+PT_BYTES*t]};
      assign en_c = {cfg[B+PT_BYTES*t+2], cfg[B+PT_BYTES*t+1][7:4]};
      // A term with no input enabled reads zero, so unused terms never fire
      assign term[t] = (|(en_t | en_c))
                     & (&(~en_t | ARR_IN[a]))
                     & (&(~en_c | ~ARR_IN[a]));  // [RQ1] [RQ2]
    end
    for (genvar o = 0; o < ARR_NOUT; o++) begin : g_or
      // Every output sees all eight terms through its own mask
      assign sop[o] = |(term & cfg[B+ARR_OR_OFS+o]);  // [RQ3]
    end
    assign reg_mode = cfg[B+ARR_REG_OFS][ARR_NOUT-1:0];
    // Registered copies give the state bits for sequencers
    always_ff @(posedge CLK) begin
      sop_q <= RST ? '0 : sop;
    end
    assign ARR_OUT[a] = (reg_mode & sop_q) | (~reg_mode & sop);  // [RQ4]
  end
  //==========================================================================
  // Byte queues: zero is filled by the bus, one is drained by the bus
  clt_cw_s         cw;                      // Selected control word
  wire logic       need_q0, need_q1, step;
  wire logic       q0_valid, q0_ready, q0_pop, q1_valid, q1_ready, q1_push;
  wire logic       q0_in_ready, q1_in_valid;
  wire logic [DW-1:0] q0_head, q1_head, q1_in_data, alu_res;
  wire logic [Q_LW-1:0] q0_level, q1_level;
  assign cw       = clt_cw_s'(cstore[CFG_SEL]);  // [RQ7]
  assign need_q0  = (cw.q0_load != FL_NONE);
  assign need_q1  = (cw.q1_cap != FC_NONE);
  // The step halts while a needed entry is missing or a slot is not free
  assign STALL    = (need_q0 & ~q0_valid) | (need_q1 & ~q1_ready);  // [RQ13]
  assign step     = ~STALL;
  assign q0_pop   = need_q0 & step;
  // Bus pops only while the datapath does not use the queue
  assign q0_ready = q0_pop | (rd_q0 & ~need_q0);  // [RQ14]
  assign q1_push  = need_q1 & ~(need_q0 & ~q0_valid);
  assign q1_in_valid = q1_push | (wr_q1 & ~need_q1);
  assign q1_in_data  = ~need_q1 ? BUS_REQ.wdata
                     : (cw.q1_cap == FC_ACC0) ? acc0
                     : (cw.q1_cap == FC_ACC1) ? acc1 : alu_res;  // [RQ13]
  clt_fifo #(.WIDTH(DW), .DEPTH(Q_DEPTH)) u_q0 (  // [RQ12]
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (wr_q0),
    .in_ready  (q0_in_ready),
    .in_data   (BUS_REQ.wdata),
    .out_valid (q0_valid),
    .out_ready (q0_ready),
    .out_data  (q0_head),
    .level     (q0_level)
  );
  clt_fifo #(.WIDTH(DW), .DEPTH(Q_DEPTH)) u_q1 (  // [RQ12]
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (q1_in_valid),
    .in_ready  (q1_ready),
    .in_data   (q1_in_data),
    .out_valid (q1_valid),
    .out_ready (rd_q1),
    .out_data  (q1_head),
    .level     (q1_level)
  );
  //==========================================================================
  // ALU: operands, function, shift
  wire logic [DW-1:0] op_a, op_b;
  wire logic          cin, shin;
  logic [DW:0]        sum;      // Ninth bit is carry or borrow
  logic               ovf;      // Signed overflow
  logic [DW-1:0]      shifted;  // After shift unit
  logic               sh_out;   // Bit shifted out
  assign op_a = cw.src_a ? acc1 : acc0;  // [RQ10]
  assign op_b = (cw.src_b == SB_OPR0) ? opr0
              : (cw.src_b == SB_OPR1) ? opr1
              : (cw.src_b == SB_PI) ? PAR_IN : acc1;  // [RQ11] [RQ17]
  assign cin  = cw.chain_ci & CHAIN_CI;  // [RQ16]
  assign shin = cw.chain_sh & CHAIN_SI;  // [RQ16]
  // Function select, one result per cycle
  always_comb begin
    ovf = 1'b0;
    case (cw.func)
      FN_INC:  sum = {1'b0, op_a} + (DW+1)'(1);
      FN_DEC:  sum = {1'b0, op_a} - (DW+1)'(1);
      FN_ADD: begin
        sum = {1'b0, op_a} + {1'b0, op_b} + (DW+1)'(cin);
        ovf = (op_a[DW-1] == op_b[DW-1]) & (sum[DW-1] != op_a[DW-1]);
      end
      FN_SUB: begin
        sum = {1'b0, op_a} - {1'b0, op_b} - (DW+1)'(cin);
        ovf = (op_a[DW-1] != op_b[DW-1]) & (sum[DW-1] != op_a[DW-1]);
      end
      FN_AND:  sum = {1'b0, op_a & op_b};
      FN_OR:   sum = {1'b0, op_a | op_b};
      FN_XOR:  sum = {1'b0, op_a ^ op_b};
      default: sum = {1'b0, op_a};  // Pass
    endcase
  end  // [RQ6]
  // Shift unit, independent of the function
  always_comb begin
    sh_out = 1'b0;
    case (cw.shift)
      SH_LEFT: begin
        shifted = {sum[DW-2:0], shin};
        sh_out  = sum[DW-1];
      end
      SH_RIGHT: begin
        shifted = {shin, sum[DW-1:1]};
        sh_out  = sum[0];
      end
      SH_SWAP: shifted = {sum[DW/2-1:0], sum[DW-1:DW/2]};
      default: shifted = sum[DW-1:0];
    endcase
  end
  assign alu_res  = shifted;
  assign CHAIN_CO = sum[DW];  // [RQ16]
  assign CHAIN_SO = sh_out;   // [RQ16]
  //==========================================================================
  // Next register values; bus write wins, then queue load, then ALU
  wire logic [DW-1:0] next_acc0, next_acc1, next_opr0, next_opr1;
  wire logic ld_acc0, ld_opr0, ld_opr1, dst_acc0, dst_acc1;
  assign ld_acc0  = q0_pop & (cw.q0_load == FL_ACC0);
  assign ld_opr0  = q0_pop & (cw.q0_load == FL_OPR0);
  assign ld_opr1  = q0_pop & (cw.q0_load == FL_OPR1);
  assign dst_acc0 = step & (cw.dest == DST_ACC0);
  assign dst_acc1 = step & (cw.dest == DST_ACC1);
  assign next_acc0 = RST ? BYTE_ZERO : wr_acc0 ? BUS_REQ.wdata  // [RQ15]
                   : ld_acc0 ? q0_head : dst_acc0 ? alu_res : acc0;  // [RQ18] [RQ13]
  assign next_acc1 = RST ? BYTE_ZERO : wr_acc1 ? BUS_REQ.wdata
                   : dst_acc1 ? alu_res : acc1;  // [RQ18] [RQ10]
  // Operand registers are never a destination of the ALU
  assign next_opr0 = RST ? BYTE_ZERO : wr_opr0 ? BUS_REQ.wdata
                   : ld_opr0 ? q0_head : opr0;  // [RQ11]
  assign next_opr1 = RST ? BYTE_ZERO : wr_opr1 ? BUS_REQ.wdata
                   : ld_opr1 ? q0_head : opr1;  // [RQ11]
  // Working registers
  always_ff @(posedge CLK) begin
    acc0 <= next_acc0;
    acc1 <= next_acc1;
    opr0 <= next_opr0;
    opr1 <= next_opr1;
  end  // [RQ9]
  //==========================================================================
  // Conditions from the next values, so they match the registers after the edge
  clt_cond_s next_cond;
  // One driver for the whole struct
  assign next_cond = '{cmp:  {next_acc1 == next_opr1, next_acc0 == next_opr0},
                       zero: {next_acc1 == BYTE_ZERO, next_acc0 == BYTE_ZERO},
                       ones: {next_acc1 == BYTE_ONES, next_acc0 == BYTE_ONES},
                       ovf:  ~RST & step & ovf};
  always_ff @(posedge CLK) begin
    cond_q <= next_cond;  // [RQ8]
    par_q  <= RST ? BYTE_ZERO : step ? alu_res : par_q;  // [RQ17]
  end
  assign COND    = cond_q;
  assign PAR_OUT = par_q;
  //==========================================================================
  // Read-back; a queue read returns the head and pops it, queue zero only while the selected word does not load from it
  wire logic [DW-1:0] rd_mux, status;
  assign status = {BYTE_ZERO[DW-1:4], ~q1_ready, ~q1_valid, ~q0_in_ready, ~q0_valid};
  assign rd_mux = (BUS_REQ.addr == ADR_ACC0) ? acc0
                : (BUS_REQ.addr == ADR_ACC1) ? acc1
                : (BUS_REQ.addr == ADR_OPR0) ? opr0
                : (BUS_REQ.addr == ADR_OPR1) ? opr1
                : (BUS_REQ.addr == ADR_Q0)   ? (q0_valid ? q0_head : BYTE_ZERO)
                : (BUS_REQ.addr == ADR_Q1)   ? (q1_valid ? q1_head : BYTE_ZERO)
                : (BUS_REQ.addr == ADR_STAT) ? status : BYTE_ZERO;  // [RQ15]
  always_ff @(posedge CLK) begin
    BUS_RDATA <= RST ? BYTE_ZERO : BUS_REQ.rd ? rd_mux : BUS_RDATA;
  end
  //==========================================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  acc_result_a: assert property (  // [RQ18]
    dst_acc0 && !wr_acc0 && !ld_acc0 |=> acc0 == $past(alu_res))
    else $error("accumulator zero missed the ALU result");
  opr_hold_a: assert property (  // [RQ11]
    step && !wr_opr1 && !ld_opr1 |=> $stable(opr1))
    else $error("operand register one changed without a load");
  q0_load_a: assert property (  // [RQ13]
    ld_opr0 && !wr_opr0 |=> opr0 == $past(q0_head) && q0_level == $past(q0_level) - 3'(1)
                          + 3'($past(wr_q0 && q0_in_ready)))
    else $error("queue zero load went wrong");
  q_depth_a: assert property (  // [RQ12]
    q0_level <= 3'(Q_DEPTH) && q1_level <= 3'(Q_DEPTH) && (q1_level == 3'(Q_DEPTH)) == !q1_ready)
    else $error("queue level beyond four");
  stall_a: assert property (  // [RQ13]
    need_q1 && !q1_ready && !wr_acc0 && !ld_acc0 |=> $stable(acc0) && $stable(PAR_OUT))
    else $error("datapath moved while stalled");
  zero_flag_a: assert property (  // [RQ8]
    COND.zero[0] == (acc0 == BYTE_ZERO) && COND.ones[1] == (acc1 == BYTE_ONES))
    else $error("zero or ones flag disagrees");
  cmp_flag_a: assert property (  // [RQ8]
    COND.cmp[1] == (acc1 == opr1) && COND.cmp[0] == (acc0 == opr0))
    else $error("compare flag disagrees");
  bus_read_a: assert property (  // [RQ15]
    BUS_REQ.rd && BUS_REQ.addr == ADR_OPR1 |=> BUS_RDATA == $past(opr1))
    else $error("bus read of operand register one wrong");
  par_out_a: assert property (  // [RQ17]
    step |=> PAR_OUT == $past(alu_res))
    else $error("parallel output missed the result");
  arr_reg_a: assert property (  // [RQ4]
    cfg[ARR_REG_OFS][1] && $past(cfg[ARR_REG_OFS][1])
      |-> ARR_OUT[0][1] == $past(g_arr[0].sop[1]))
    else $error("registered sum output wrong");
  cv_add_c: cover property (step && cw.func == FN_ADD && cw.dest == DST_ACC0);
  cv_q1_full_c: cover property (!q1_ready);
  cv_stall_c: cover property (STALL ##1 !STALL);
  cv_arr_c: cover property (ARR_OUT[0] != '0);
endmodule : clt_tile
`default_nettype wire
